// >>> logic/isc_pkg.sv
// Package with register map, field layout and bus types of the source control.
package isc_pkg;

  localparam int unsigned NUM_SRC      = 32;
  localparam int unsigned PRIO_W       = 3;
  localparam int unsigned SUB_W        = 2;
  localparam int unsigned SRC_IDX_W    = 5;
  localparam int unsigned NUM_PRIO_REG = 8;

  // Byte offsets of the registers on the bus, one 32-bit word apart, except a two-word step from PENDING to the priority block.
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_RELOAD    = 8'h04;
  localparam logic [7:0] OFS_FLAGS     = 8'h08;
  localparam logic [7:0] OFS_ENABLE    = 8'h0C;
  localparam logic [7:0] OFS_EVT_STAT  = 8'h10;
  localparam logic [7:0] OFS_EVT_MASK  = 8'h14;
  localparam logic [7:0] OFS_PENDING   = 8'h18;
  localparam logic [7:0] OFS_PRIO_BASE = 8'h20;

  // Control register fields.
  localparam int unsigned CTL_TRIG_LSB = 8;
  localparam int unsigned CTL_MULTI_VECTOR_SELECT_BIT = 12;

  // Priority register layout: one byte per source.
  localparam int unsigned PRIO_LSB  = 2;
  localparam int unsigned SUB_LSB   = 0;
  localparam int unsigned BYTE_W    = 8;
  localparam logic [7:0]  BYTE_MASK = 8'h1F;

  // Event status bits.
  localparam int unsigned EVT_EXPIRE = 0;
  localparam int unsigned EVT_NEWREQ = 1;
  localparam int unsigned EVT_W      = 2;

  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic                  valid;
    logic [PRIO_W-1:0]     prio;
    logic [SUB_W-1:0]      sub;
    logic [SRC_IDX_W-1:0]  src;
  } isc_req_type;

  typedef struct packed {
    logic         sel;
    logic [31:0]  addr;
    logic [1:0]   trans;
    logic         write;
    logic [2:0]   size;
    logic         ready;
  } isc_ahb_req_type;

endpackage

// >>> logic/isc_arbiter.sv
// Picks the best pending source by priority, then subpriority.
`timescale 1ns/1ps
module isc_arbiter
  import isc_pkg::*;
(
  input  wire logic [NUM_SRC-1:0]        i_pending,
  input  wire logic [NUM_SRC*PRIO_W-1:0] i_prio,
  input  wire logic [NUM_SRC*SUB_W-1:0]  i_sub,
  output isc_req_type                    o_best
);

  // A linear scan keeps the logic simple; lower index wins ties.
  always_comb begin
    isc_req_type cand;
    cand   = '0;
    o_best = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      cand.valid = i_pending[i];
      cand.prio  = i_prio[i*PRIO_W +: PRIO_W];
      cand.sub   = i_sub[i*SUB_W +: SUB_W];
      cand.src   = SRC_IDX_W'(i);
      if (cand.valid && (!o_best.valid ||
          {cand.prio, cand.sub} > {o_best.prio, o_best.sub})) begin // [RQ11]
        o_best = cand;
      end
    end
  end

endmodule

// >>> logic/isc_top.sv
// Interrupt source control with AHB-Lite register slave and proximity timer.
// Overview of operation
// [RQ1] A 32-bit writable reload value is loaded into the proximity timer on each qualifying event.
// [RQ2] Each source has a readable and writable request flag that shows a raised request.
// [RQ3] Each source has an enable bit, 1 permits and 0 blocks, cleared at reset.
// [RQ4] Each source has a 3-bit priority, codes 1 to 7 meaning levels 1 to 7.
// [RQ5] A priority of zero disables the source regardless of its enable; here an enabled zero-priority source still sets the new-request event status.
// [RQ6] Each source has a 2-bit subpriority giving levels 0 to 3.
// [RQ7] A priority register packs four sources, one per byte, priority above subpriority.
// [RQ8] The top three bits of every priority byte ignore writes and read zero.
// [RQ9] A 3-bit trigger level lets priorities up to n start the timer, zero disables it.
// [RQ10] A control bit selects multi-vector mode when set, single-vector when clear.
// [RQ11] A request goes out only for flagged, enabled, nonzero-priority sources, best first.
// [RQ12] A request flag stays set until software clears it.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module isc_top
  import isc_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic [31:0]               o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp,
  input  wire logic [NUM_SRC-1:0]   i_src_event,
  output logic                      o_req_valid,
  output logic [PRIO_W-1:0]         o_req_prio,
  output logic [SUB_W-1:0]          o_req_sub,
  output logic [SRC_IDX_W-1:0]      o_req_src,
  output logic                      o_multi_vector,
  output logic                      o_prox_active,
  output logic                      o_irq
);

  isc_ahb_req_type  bus;
  isc_ahb_req_type  dph_q;
  logic             wr_en;
  logic [7:0]       wofs;
  logic [NUM_SRC-1:0] flags_q;
  logic [NUM_SRC-1:0] enable_q;
  logic [31:0]      reload_q;
  logic [31:0]      timer_q;
  logic [2:0]       trig_q;
  logic             multi_vector_q;
  logic [31:0]      prio_reg_q [NUM_PRIO_REG];
  logic [EVT_W-1:0] evt_stat_q;
  logic [EVT_W-1:0] evt_mask_q;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC*PRIO_W-1:0] prio_vec;
  logic [NUM_SRC*SUB_W-1:0]  sub_vec;
  isc_req_type      best;
  logic [NUM_SRC-1:0] new_req;
  logic             prox_trigger;
  logic             timer_expire;
  logic [31:0]      rdata_d;

  assign bus.sel   = i_hsel;
  assign bus.addr  = i_haddr;
  assign bus.trans = i_htrans;
  assign bus.write = i_hwrite;
  assign bus.size  = i_hsize;
  assign bus.ready = i_hready;

  // Address phase is captured; the write lands in the data phase.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dph_q <= '0;
    end else if (i_hready) begin
      dph_q     <= bus;
      dph_q.sel <= i_hsel && (i_htrans == HTRANS_NONSEQ);
    end
  end

  // Upper address bits must be clear, so an alias cannot hit a register.
  assign wr_en       = dph_q.sel && dph_q.write &&
                       (dph_q.addr[31:8] == '0);
  assign wofs        = dph_q.addr[7:0];
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // Priority and subpriority pulled out of the packed bytes.
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      prio_vec[i*PRIO_W +: PRIO_W] =
        prio_reg_q[i/4][(i%4)*BYTE_W + PRIO_LSB +: PRIO_W]; // [RQ4] [RQ7]
      sub_vec[i*SUB_W +: SUB_W] =
        prio_reg_q[i/4][(i%4)*BYTE_W + SUB_LSB +: SUB_W]; // [RQ6] [RQ7]
    end
  end

  // Priority zero masks a source even when enabled.
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      pend[i] = flags_q[i] && enable_q[i] &&
                (prio_vec[i*PRIO_W +: PRIO_W] != '0); // [RQ3] [RQ5] [RQ11]
    end
  end

  isc_arbiter u_arb (
    .i_pending (pend),
    .i_prio    (prio_vec),
    .i_sub     (sub_vec),
    .o_best    (best)
  );

  // Request flags: hardware sets win over a software write of zero.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags_q <= RST_WORD;
    end else begin
      if (wr_en && wofs == OFS_FLAGS) begin
        flags_q <= i_hwdata | i_src_event; // [RQ2] [RQ12]
      end else begin
        flags_q <= flags_q | i_src_event; // [RQ12]
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      enable_q <= RST_WORD;
    end else if (wr_en && wofs == OFS_ENABLE) begin
      enable_q <= i_hwdata; // [RQ3]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reload_q <= RST_WORD;
    end else if (wr_en && wofs == OFS_RELOAD) begin
      reload_q <= i_hwdata; // [RQ1]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      trig_q         <= '0;
      multi_vector_q <= 1'b0;
    end else if (wr_en && wofs == OFS_CONTROL) begin
      trig_q         <= i_hwdata[CTL_TRIG_LSB +: 3]; // [RQ9]
      multi_vector_q <= i_hwdata[CTL_MULTI_VECTOR_SELECT_BIT]; // [RQ10]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int r = 0; r < NUM_PRIO_REG; r++) begin
        prio_reg_q[r] <= RST_WORD;
      end
    end else if (wr_en && wofs >= OFS_PRIO_BASE &&
                 wofs < OFS_PRIO_BASE + 8'(4 * NUM_PRIO_REG)) begin
      prio_reg_q[3'(wofs[4:2])] <= i_hwdata & {4{BYTE_MASK}}; // [RQ8]
    end
  end

  // A new request is an event this cycle on an enabled source whose flag is still clear.
  assign new_req = i_src_event & ~flags_q & enable_q;

  // Any new request whose priority is within the trigger level starts it.
  always_comb begin
    prox_trigger = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (new_req[i] && trig_q != '0 &&
          prio_vec[i*PRIO_W +: PRIO_W] != '0 &&
          prio_vec[i*PRIO_W +: PRIO_W] <= trig_q) begin // [RQ9]
        prox_trigger = 1'b1;
      end
    end
  end

  // Timer counts down to zero; a fresh trigger reloads it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timer_q <= RST_WORD;
    end else if (prox_trigger) begin
      timer_q <= reload_q; // [RQ1]
    end else if (timer_q != '0) begin
      timer_q <= timer_q - 32'h0000_0001;
    end
  end

  assign timer_expire  = (timer_q == 32'h0000_0001) && !prox_trigger;
  assign o_prox_active = (timer_q != '0);

  // While the proximity timer runs, requests are held back to coalesce.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_req_valid <= 1'b0;
      o_req_prio  <= '0;
      o_req_sub   <= '0;
      o_req_src   <= '0;
    end else begin
      o_req_valid <= best.valid && (timer_q == '0) && !prox_trigger; // [RQ11]
      o_req_prio  <= best.prio;
      o_req_sub   <= best.sub;
      o_req_src   <= best.src;
    end
  end

  assign o_multi_vector = multi_vector_q;

  // Event status: write one to clear, a new event in the same cycle wins.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_stat_q <= '0;
    end else begin
      evt_stat_q <= (evt_stat_q &
                     ~((wr_en && wofs == OFS_EVT_STAT) ?
                       i_hwdata[EVT_W-1:0] : '0)) |
                    {|new_req, timer_expire};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_mask_q <= '0;
    end else if (wr_en && wofs == OFS_EVT_MASK) begin
      evt_mask_q <= i_hwdata[EVT_W-1:0];
    end
  end

  assign o_irq = |(evt_stat_q & evt_mask_q);

  // Read data is looked up from the address phase and registered.
  always_comb begin
    rdata_d = '0;
    if (bus.addr[7:0] >= OFS_PRIO_BASE &&
        bus.addr[7:0] < OFS_PRIO_BASE + 8'(4 * NUM_PRIO_REG) &&
        bus.addr[31:8] == '0) begin
      rdata_d = prio_reg_q[3'(bus.addr[4:2])]; // [RQ8]
    end else if (bus.addr[31:8] == '0) begin
      unique case (bus.addr[7:0])
        OFS_CONTROL: begin
          rdata_d[CTL_TRIG_LSB +: 3] = trig_q;
          rdata_d[CTL_MULTI_VECTOR_SELECT_BIT]      = multi_vector_q;
        end
        OFS_RELOAD:   rdata_d = reload_q;
        OFS_FLAGS:    rdata_d = flags_q; // [RQ2]
        OFS_ENABLE:   rdata_d = enable_q;
        OFS_EVT_STAT: rdata_d[EVT_W-1:0] = evt_stat_q;
        OFS_EVT_MASK: rdata_d[EVT_W-1:0] = evt_mask_q;
        OFS_PENDING:  rdata_d = pend;
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hrdata <= '0;
    end else if (i_hready && i_hsel && i_htrans == HTRANS_NONSEQ &&
                 !i_hwrite) begin
      o_hrdata <= rdata_d;
    end
  end

endmodule

// >>> sim/isc_props.sv
// Checker of bus, request and proximity timing of the source control.
`timescale 1ns/1ps
module isc_props
  import isc_pkg::*;
(
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic               i_hsel,
  input wire logic [31:0]        i_haddr,
  input wire logic [1:0]         i_htrans,
  input wire logic               i_hwrite,
  input wire logic               i_hready,
  input wire logic [NUM_SRC-1:0] i_src_event,
  input wire logic [31:0]        o_hrdata,
  input wire logic               o_hreadyout,
  input wire logic               o_hresp,
  input wire logic               o_req_valid,
  input wire logic [PRIO_W-1:0]  o_req_prio,
  input wire logic               o_multi_vector,
  input wire logic               o_prox_active,
  input wire logic               o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic taken;
  logic wr_q;
  logic rd_q;
  assign taken = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ);
  always_ff @(posedge i_clk) begin
    wr_q <= taken & i_hwrite & (i_haddr == {24'h000000, OFS_CONTROL});
    rd_q <= taken & !i_hwrite;
  end
  property p_ready; o_hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_okay; o_hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_rst;
    @(posedge i_clk) disable iff (1'b0)
    $fell(i_rst) |-> !o_req_valid && !o_irq && !o_prox_active;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear");
  property p_hold; o_prox_active && $past(o_prox_active) |-> !o_req_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("request not held");
  property p_prio; o_req_valid |-> o_req_prio != 3'h0; endproperty
  a_prio: assert property (p_prio) else $error("zero priority out");
  property p_multi_vector_select;
    $changed(o_multi_vector) |-> $past(wr_q) || $past(wr_q, 2);
  endproperty
  a_multi_vector_select: assert property (p_multi_vector_select) else $error("mode moved alone");
  property p_rdata; $changed(o_hrdata) |-> $past(taken) || $past(rd_q);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_start;
    $rose(o_prox_active) |-> $past(|i_src_event) || $past(|i_src_event, 2);
  endproperty
  a_start: assert property (p_start) else $error("timer rose alone");
  c_req: cover property (o_req_valid);
  c_prox: cover property ($rose(o_prox_active));
  c_irq: cover property (o_irq);
endmodule
bind isc_top isc_props props_u (.*);

// >>> sim/isc_core_model.sv
// Core-side model that takes each presented request.
`timescale 1ns/1ps
module isc_core_model
  import isc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire isc_req_type i_req,
  output logic [9:0]       o_taken
);
  // No acknowledge exists, so the core simply keeps the latest winner.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_taken <= 10'h000;
    end else if (i_req.valid) begin
      o_taken <= {i_req.prio, i_req.sub, i_req.src};
    end
  end
endmodule

// >>> sim/testbench.sv
// Bench driving registers and source events of the source control.
`timescale 1ns/1ps
module testbench
  import isc_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] src;
  logic [31:0] r;
  logic [9:0]  taken;
  logic        valid;
  logic        prox;
  logic        multi_vector_select;
  logic        irq;
  logic [2:0]  rprio;
  logic [1:0]  rsub;
  logic [4:0]  rsrc;
  isc_req_type req;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  isc_top dut_u (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
    .i_src_event(src), .o_req_valid(valid), .o_req_prio(rprio),
    .o_req_sub(rsub), .o_req_src(rsrc), .o_multi_vector(multi_vector_select),
    .o_prox_active(prox), .o_irq(irq));
  assign req = {valid, rprio, rsub, rsrc};
  isc_core_model core_u (.i_clk(clk), .i_rst(rst), .i_req(req),
    .o_taken(taken));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  function automatic logic [31:0] ad(input logic [7:0] o);
    return {24'h000000, o};
  endfunction
  task automatic rc(input string n, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask
  task automatic ev(input int s);
    src[s] <= 1'b1;
    @(posedge clk);
    src <= 32'h0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata, src} = {1'b1, 101'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc("reload", ad(OFS_RELOAD), RST_WORD);
    rc("flags", ad(OFS_FLAGS), RST_WORD);
    rc("enable", ad(OFS_ENABLE), RST_WORD);
    bus(1'b1, ad(OFS_PRIO_BASE), 32'hFFFFFFFF);
    rc("prio_bits", ad(OFS_PRIO_BASE), 32'h1F1F1F1F);
    bus(1'b1, ad(OFS_RELOAD), 32'hA5C396F0);
    rc("reload_rw", ad(OFS_RELOAD), 32'hA5C396F0);
    bus(1'b1, 32'h100, 32'hFFFFFFFF);
    rc("unmapped", 32'h100, 32'h0);
    rc("ctl_kept", ad(OFS_CONTROL), 32'h0);
    bus(1'b1, ad(OFS_PRIO_BASE), 32'h0);
    bus(1'b1, ad(OFS_RELOAD), 32'h14);
    bus(1'b1, ad(OFS_ENABLE), 32'h70);
    bus(1'b1, ad(OFS_PRIO_BASE + 8'h04), 32'h000F0E00);
    ev(5);
    rc("sticky", ad(OFS_FLAGS), 32'h20);
    chk("first", {22'h0, taken}, {22'h0, 10'h1C5});
    chk("no_timer", {31'h0, prox}, 32'h0);
    ev(6);
    chk("sub_wins", {22'h0, taken}, {22'h0, 10'h1E6});
    bus(1'b1, ad(OFS_PRIO_BASE + 8'h04), 32'h000F0E1C);
    ev(4);
    chk("prio_wins", {22'h0, taken}, {22'h0, 10'h384});
    bus(1'b1, ad(OFS_PRIO_BASE + 8'h04), 32'h0);
    repeat (3) @(posedge clk);
    chk("prio_zero", {31'h0, valid}, 32'h0);
    bus(1'b1, ad(OFS_PRIO_BASE + 8'h04), 32'h1C);
    bus(1'b1, ad(OFS_ENABLE), 32'h0);
    repeat (3) @(posedge clk);
    chk("enable_off", {31'h0, valid}, 32'h0);
    bus(1'b1, ad(OFS_FLAGS), 32'h0);
    rc("cleared", ad(OFS_FLAGS), 32'h0);
    bus(1'b1, ad(OFS_CONTROL), 32'h00001700);
    @(posedge clk);
    chk("multi", {31'h0, multi_vector_select}, 32'h1);
    rc("control", ad(OFS_CONTROL), 32'h00001700);
    bus(1'b1, ad(OFS_ENABLE), 32'h20);
    bus(1'b1, ad(OFS_PRIO_BASE + 8'h04), 32'h00000E00);
    ev(5);
    repeat (6) @(posedge clk);
    chk("timer_on", {31'h0, prox}, 32'h1);
    chk("held", {31'h0, valid}, 32'h0);
    repeat (15) @(posedge clk);
    chk("timer_off", {31'h0, prox}, 32'h0);
    chk("released", {31'h0, valid}, 32'h1);
    rc("pending", ad(OFS_PENDING), 32'h20);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    bus(1'b0, ad(OFS_EVT_STAT), 32'h0);
    chk("evt_stat", r, 32'h3);
    bus(1'b1, ad(OFS_EVT_MASK), 32'h1);
    @(posedge clk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    bus(1'b1, ad(OFS_EVT_STAT), 32'h1);
    @(posedge clk);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    bus(1'b1, ad(OFS_FLAGS), 32'h0);
    bus(1'b1, ad(OFS_CONTROL), 32'h00001200);
    ev(5);
    chk("above_trig", {31'h0, prox}, 32'h0);
    chk("not_held", {31'h0, valid}, 32'h1);
    wrap_up;
  end
endmodule
